// [sim/spi_host_model.sv]
// host side of the mode-1 link: drives select, clock and data in
// assumes the bench clock clk; half a link period is four clk cycles (80 ns)
`timescale 1ns/1ps
module spi_host_model
  import adc_seq_pkg::*;
(
  input  wire logic clk,  // system clock
  input  wire logic miso, // shared data out pin
  output spi_in_type spi  // select, clock, data in
);
  initial spi = '{cs_n: 1'b1, sclk: 1'b0, din: 1'b1}; // clock idles low

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask

  // select held low for the whole frame
  task automatic select(input logic lvl);
    wait_clk(8);
    spi.cs_n <= lvl;
    if (lvl)
    begin
      spi.din <= ~spi.din;
    end
    wait_clk(8);
  endtask

  // msb first; launch on rising edge, sample just after falling edge
  task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nb; i--)
    begin
      @(posedge clk);
      spi.sclk <= 1'b1;
      spi.din  <= tx[i];
      wait_clk(4);
      spi.sclk <= 1'b0;
      @(negedge clk);
      rx[i] = miso;
      wait_clk(3);
    end
  endtask
endmodule

// [sim/tb_adc_spi_command_sequencer.sv]
// self-checking bench of the serial command sequencer
// assumes the host model drives the link; the bench feeds sample words
`timescale 1ns/1ps
module tb_adc_spi_command_sequencer;
  import adc_seq_pkg::*;
  localparam int POR_N    = 50;
  localparam int CONV_N   = 400;
  localparam int SETTLE_N = 410;
  localparam int LIMIT    = 60000;
  logic                clk, reset, start_pin, sample_valid, sample_ready;
  logic                dpin, doe, data_ready_n_n, pdown;
  logic [RESULT_W-1:0] sample_data, w;
  logic [BYTE_W-1:0]   in_sel, sys_ctl, rxb;
  logic [BYTE_W-1:0]   wr_seq [6] = '{8'h40, 8'h03, 8'h01, 8'h00, 8'h03, 8'h42};
  logic [BYTE_W-1:0]   rd_exp [4] = '{8'h01, 8'h00, 8'h03, 8'h42};
  spi_in_type          spi;
  int                  mismatches, n_checks, cycles, n;

  adc_spi_command_sequencer #(
    .POR_COUNT    (POR_N),
    .CONV_COUNT   (CONV_N),
    .SETTLE_COUNT (SETTLE_N)
  ) u_dut (
    .clk                     (clk),
    .reset                   (reset),
    .spi_in                  (spi),
    .start_pin               (start_pin),
    .sample_data             (sample_data),
    .sample_valid            (sample_valid),
    .sample_ready            (sample_ready),
    .data_out_ready_pin      (dpin),
    .data_out_ready_oe       (doe),
    .data_ready_n            (data_ready_n_n),
    .power_down              (pdown),
    .input_select_register   (in_sel),
    .system_control_register (sys_ctl)
  );
  spi_host_model u_host (
    .clk  (clk),
    .miso (dpin),
    .spi  (spi)
  );

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      mismatches++;
      test_done();
    end
  end

  task automatic send(input logic [7:0] b);
    u_host.xfer(b, 8, rxb);
    // let the last byte's effects settle before callers look
    @(negedge clk);
  endtask

  task automatic get_word(output logic [15:0] v);
    send(8'h00);
    v[15:8] = rxb;
    send(8'h00);
    v[7:0] = rxb;
  endtask

  task automatic offer(input logic [15:0] v);
    int k;
    k = 0;
    @(posedge clk);
    sample_data  <= v;
    sample_valid <= 1'b1;
    @(negedge clk);
    while (sample_ready !== 1'b1 && k < 2000)
    begin
      @(negedge clk);
      k++;
    end
    @(posedge clk);
    sample_valid <= 1'b0;
  endtask

  task automatic wait_low(input int lim);
    n = 0;
    @(negedge clk);
    while (data_ready_n_n !== 1'b0 && n < lim)
    begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic t_power_up();
    u_host.select(1'b0);
    check("oe in hold", 16'(doe), 16'h0000);
    check("ready idle", 16'(data_ready_n_n), 16'h0001);
    check("regs reset", {in_sel, sys_ctl}, 16'h0000);
    u_host.wait_clk(POR_N);
    @(negedge clk);
    check("oe after hold", 16'(doe), 16'h0001);
    u_host.select(1'b1);
  endtask

  task automatic t_continuous();
    offer(16'hA5C3);
    offer(16'h3C5A);
    @(negedge clk);
    check("buffer full", 16'(sample_ready), 16'h0000);
    @(posedge clk);
    start_pin <= 1'b1;
    wait_low(CONV_N + 20);
    check("first ready", 16'(data_ready_n_n), 16'h0000);
    u_host.select(1'b0);
    send(8'h40);
    w[15:8] = rxb;
    send(8'h00);
    w[7:0] = rxb;
    check("cont result", w, 16'hA5C3);
    send(8'h01);
    wait_low(SETTLE_N + 20);
    check("settle time", 16'(n >= SETTLE_N - 8 && n <= SETTLE_N + 8), 16'h0001);
    check("input select", 16'(in_sel), 16'h0001);
    u_host.select(1'b1);
  endtask

  task automatic t_registers();
    u_host.select(1'b0);
    send(CMD_RESET);
    @(negedge clk);
    check("soft reset", 16'(in_sel), 16'h0000);
    u_host.wait_clk(30000);
    send(CMD_STOP_CONT);
    foreach (wr_seq[i]) send(wr_seq[i]);
    check("block write", {in_sel, sys_ctl}, 16'h0142);
    send(8'h20);
    send(8'h03);
    foreach (rd_exp[i])
    begin
      send(8'h00);
      check("block read", 16'(rxb), 16'(rd_exp[i]));
    end
    u_host.select(1'b1);
    u_host.select(1'b0);
    u_host.xfer(8'h40, 4, rxb);
    u_host.select(1'b1);
    u_host.select(1'b0);
    send(8'h40);
    send(8'h00);
    send(8'h77);
    u_host.select(1'b1);
    check("partial dropped", 16'(in_sel), 16'h0077);
  endtask

  task automatic t_stopped_read();
    // restart the period so the next result lands at a known time
    u_host.select(1'b0);
    send(CMD_SYNC);
    offer(16'h5AA5);
    u_host.wait_clk(CONV_N + 20);
    get_word(w);
    check("no push", 16'(data_ready_n_n), 16'h0000);
    send(CMD_READ_DATA);
    get_word(w);
    check("read data", w, 16'h5AA5);
    check("ready cleared", 16'(data_ready_n_n), 16'h0001);
    u_host.select(1'b1);
  endtask

  task automatic t_power_down();
    offer(16'hC33C);
    start_pin <= 1'b0;
    n = 0;
    @(negedge clk);
    while (pdown !== 1'b1 && n < CONV_N + 20)
    begin
      @(negedge clk);
      n++;
    end
    check("down on ready", {7'h00, pdown, 7'h00, data_ready_n_n}, 16'h0100);
    u_host.select(1'b0);
    send(CMD_READ_DATA);
    get_word(w);
    check("read in sleep", w, 16'hC33C);
    u_host.select(1'b1);
    start_pin <= 1'b1;
    u_host.wait_clk(6);
    check("wake", 16'(pdown), 16'h0000);
    offer(16'h0F0F);
    u_host.select(1'b0);
    send(CMD_SYNC);
    wait_low(CONV_N + 20);
    check("sync period", 16'(n >= CONV_N - 12 && n <= CONV_N + 4), 16'h0001);
    send(CMD_SLEEP);
    @(negedge clk);
    check("sleep", 16'(pdown), 16'h0001);
    u_host.select(1'b1);
  endtask

  initial
  begin
    reset        = 1'b1;
    start_pin    = 1'b0;
    sample_valid = 1'b0;
    sample_data  = 16'h0000;
    mismatches   = 0;
    n_checks     = 0;
    cycles       = 0;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    t_power_up();
    t_continuous();
    t_registers();
    t_stopped_read();
    t_power_down();
    test_done();
  end
endmodule

// [src/adc_seq_pkg.sv]
// constants, types and command codes shared by the serial command sequencer
// assumes a single 50 MHz system clock; times are converted to cycle counts here
package adc_seq_pkg;

  localparam int      CLK_HZ          = 50_000_000;
  localparam int      CLK_PERIOD_NS   = 20;
  localparam longint  CONV_CLK_HZ     = 4_096_000;
  localparam longint  POR_CONV_CYCLES = 65_536;
  // power-up hold expressed in system clocks (2^16 conversion clocks)
  localparam int      POR_CLKS        = int'((POR_CONV_CYCLES * CLK_HZ) / CONV_CLK_HZ);
  // one result period at 2 kSPS
  localparam int      CONV_TIME_NS    = 500_000;
  localparam int      CONV_CLKS       = CONV_TIME_NS / CLK_PERIOD_NS;
  // input-select write to next data-ready at 2 kSPS
  localparam int      SETTLE_TIME_NS  = 513_000;
  localparam int      SETTLE_CLKS     = SETTLE_TIME_NS / CLK_PERIOD_NS;

  localparam int      CNT_W           = 20;
  localparam int      REG_AW          = 4;
  localparam int      NUM_REGS        = 16;
  localparam int      RESULT_W        = 16;
  localparam int      BYTE_W          = 8;
  localparam int      SYNC_STAGES_W   = 4;

  localparam logic [4:0]        RESULT_BITS     = 5'h10;
  localparam logic [4:0]        BYTE_BITS       = 5'h08;
  localparam logic [2:0]        LAST_BIT        = 3'h7;
  localparam logic [BYTE_W-1:0] REG_RESET_VALUE = 8'h00;

  localparam logic [BYTE_W-1:0] CMD_SLEEP       = 8'h02;
  localparam logic [BYTE_W-1:0] CMD_SYNC        = 8'h04;
  localparam logic [BYTE_W-1:0] CMD_RESET       = 8'h06;
  localparam logic [BYTE_W-1:0] CMD_READ_DATA   = 8'h12;
  localparam logic [BYTE_W-1:0] CMD_STOP_CONT   = 8'h16;
  localparam logic [3:0]        READ_PREFIX     = 4'h2;
  localparam logic [3:0]        WRITE_PREFIX    = 4'h4;

  localparam logic [REG_AW-1:0] REG_INPUT_SELECT   = 4'h0;
  localparam logic [REG_AW-1:0] REG_SYSTEM_CONTROL = 4'h3;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic din;
  } spi_in_type;

  typedef enum logic [2:0] {
    ST_CMD     = 3'b000,
    ST_WR_CNT  = 3'b001,
    ST_WR_DATA = 3'b010,
    ST_RD_CNT  = 3'b011,
    ST_RD_DATA = 3'b100
  } seq_state_type;

endpackage

// [src/adc_spi_command_sequencer.sv]
// serial command sequencer of a delta-sigma converter, device side of a mode-1 link
// assumes pins asynchronous to clk; samples arrive on a valid/ready port
// Overview of operation
// [R1] link runs mode 1, idle-low clock, late phase
// [R2] launch on rising edge, sample on falling
// [R3] internal reset holds 2^16 conversion clocks
// [R4] host waits 16 ms after power-up
// [R5] start pin high enables conversions
// [R6] command 06h resets; host waits 0.6 ms
// [R7] command 16h stops continuous result output
// [R8] new results never disturb reads in progress
// [R9] block write: 40h+addr, count-1, data bytes
// [R10] block read: 20h+addr, count-1, bytes returned
// [R11] command 04h starts a new conversion
// [R12] chip select high clears interface state
// [R13] data ready falls when result available
// [R14] command 12h plus 16 clocks reads result
// [R15] command 02h stops conversions, powers down
// [R16] reset default is continuous read mode
// [R17] input-select write may overlap result readout
// [R18] input-select write gives data ready after 0.513 ms
// [R19] start low: finish conversion, then power down
// [R20] last result stays readable in power-down
// [R21] one block write covers first four registers
// [R22] bytes msb first, chip select held low
`timescale 1ns/1ps
module adc_spi_command_sequencer
  import adc_seq_pkg::*;
#(
  parameter int POR_COUNT    = POR_CLKS,
  parameter int CONV_COUNT   = CONV_CLKS,
  parameter int SETTLE_COUNT = SETTLE_CLKS,
  parameter int BUF_DEPTH    = 2
) (
  input  wire logic                clk,                     // 50 MHz system clock
  input  wire logic                reset,                   // synchronous, active high
  input  wire spi_in_type          spi_in,                  // chip select, clock, data in
  input  wire logic                start_pin,               // conversion enable pin
  input  wire logic [RESULT_W-1:0] sample_data,             // modulator result word
  input  wire logic                sample_valid,            // result word offered
  output logic                     sample_ready,            // buffer has room
  output logic                     data_out_ready_pin,      // shared data out / ready pin
  output logic                     data_out_ready_oe,       // pin driven
  output logic                     data_ready_n,            // dedicated ready pin
  output logic                     power_down,              // device in power-down
  output logic [BYTE_W-1:0]        input_select_register,   // channel selection
  output logic [BYTE_W-1:0]        system_control_register  // gain and data rate
);

  logic                cs_n_s;
  logic                sclk_s;
  logic                din_s;
  logic                start_s;
  logic                sclk_prev_q;
  logic                start_prev_q;
  logic                sclk_rise;
  logic                sclk_fall;
  logic                start_rise;
  logic [CNT_W-1:0]    por_cnt_q;
  logic                por_busy;
  logic [2:0]          bit_cnt_q;
  logic [BYTE_W-1:0]   rx_q;
  logic [BYTE_W-1:0]   rx_byte;
  logic                byte_done;
  seq_state_type       state_q;
  logic [REG_AW-1:0]   addr_q;
  logic [BYTE_W-1:0]   count_q;
  logic [BYTE_W-1:0]   regs_q [NUM_REGS];
  logic                in_cmd;
  logic                cmd_reset;
  logic                cmd_stop;
  logic                cmd_sync;
  logic                cmd_sleep;
  logic                cmd_rdata;
  logic                cmd_register_block_write_cmd;
  logic                cmd_register_block_read_cmd;
  logic                wr_strobe;
  logic                mux_write;
  logic                rd_load;
  logic                continuous_read_mode_q;
  logic                power_down_q;
  logic [CNT_W-1:0]    conv_cnt_q;
  logic                conv_active_q;
  logic                conv_done;
  logic [RESULT_W-1:0] result_q;
  logic [RESULT_W-1:0] buf_data;
  logic                buf_valid;
  logic                data_ready_n_n_q;
  logic [RESULT_W-1:0] tx_q;
  logic [4:0]          tx_left_q;
  logic                launch_result;
  logic                dout_q;
  logic                oe_q;

  pin_sync #(
    .WIDTH (SYNC_STAGES_W)
  ) u_pin_sync (
    .clk      (clk),
    .reset    (reset),
    .async_in ({spi_in, start_pin}),
    .sync_out ({cs_n_s, sclk_s, din_s, start_s})
  );

  pair_buffer #(
    .WIDTH (RESULT_W),
    .DEPTH (BUF_DEPTH)
  ) u_result_buffer (
    .clk       (clk),
    .reset     (reset),
    .in_data   (sample_data),
    .in_valid  (sample_valid),
    .in_ready  (sample_ready),
    .out_data  (buf_data),
    .out_valid (buf_valid),
    .out_ready (conv_done)
  );

  // edge detection on the synchronised levels
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sclk_prev_q  <= 1'b0;
      start_prev_q <= 1'b0;
    end
    else
    begin
      sclk_prev_q  <= sclk_s;
      start_prev_q <= start_s;
    end
  end

  assign sclk_rise  = sclk_s && !sclk_prev_q && !cs_n_s && !por_busy;  // [R1] [R2]
  assign sclk_fall  = !sclk_s && sclk_prev_q && !cs_n_s && !por_busy;  // [R1] [R2]
  assign start_rise = start_s && !start_prev_q;

  // power-up hold, interface and conversions ignored meanwhile
  always_ff @(posedge clk)
  begin
    if (reset)
      por_cnt_q <= CNT_W'(POR_COUNT);  // [R3]
    else if (por_busy)
      por_cnt_q <= por_cnt_q - CNT_W'(1);  // [R3]
  end

  assign por_busy = (por_cnt_q != '0);

  // receive shifter, sampled on falling clock edges
  always_ff @(posedge clk)
  begin
    if (reset || cs_n_s)
    begin
      bit_cnt_q <= 3'h0;  // [R12]
      rx_q      <= 8'h00;
    end
    else if (sclk_fall)
    begin
      rx_q      <= rx_byte;
      bit_cnt_q <= bit_cnt_q + 3'h1;
    end
  end

  assign rx_byte   = {rx_q[BYTE_W-2:0], din_s};  // [R22]
  assign byte_done = sclk_fall && (bit_cnt_q == LAST_BIT);  // [R22]

  // opcodes are decoded regardless of any result being shifted out
  assign in_cmd    = byte_done && (state_q == ST_CMD);  // [R17]
  assign cmd_reset = in_cmd && (rx_byte == CMD_RESET);  // [R6]
  assign cmd_stop  = in_cmd && (rx_byte == CMD_STOP_CONT);  // [R7]
  assign cmd_sync  = in_cmd && (rx_byte == CMD_SYNC);  // [R11]
  assign cmd_sleep = in_cmd && (rx_byte == CMD_SLEEP);  // [R15]
  assign cmd_rdata = in_cmd && (rx_byte == CMD_READ_DATA);  // [R14]
  assign cmd_register_block_write_cmd  = in_cmd && (rx_byte[7:4] == WRITE_PREFIX);  // [R9]
  assign cmd_register_block_read_cmd  = in_cmd && (rx_byte[7:4] == READ_PREFIX);  // [R10]
  assign wr_strobe = byte_done && (state_q == ST_WR_DATA);  // [R9]
  assign mux_write = wr_strobe && (addr_q == REG_INPUT_SELECT);  // [R17]
  assign rd_load   = byte_done && ((state_q == ST_RD_CNT)
                     || ((state_q == ST_RD_DATA) && (count_q != 8'h00)));  // [R10]

  // transaction sequencer
  always_ff @(posedge clk)
  begin
    if (reset || cs_n_s || por_busy)
    begin
      state_q <= ST_CMD;  // [R12]
      addr_q  <= '0;
      count_q <= 8'h00;
    end
    else if (byte_done)
    begin
      case (state_q)
        ST_CMD:
        begin
          addr_q <= rx_byte[REG_AW-1:0];
          if (cmd_register_block_write_cmd)
            state_q <= ST_WR_CNT;  // [R9]
          else if (cmd_register_block_read_cmd)
            state_q <= ST_RD_CNT;  // [R10]
        end
        ST_WR_CNT:
        begin
          count_q <= rx_byte;  // [R9]
          state_q <= ST_WR_DATA;
        end
        ST_WR_DATA:
        begin
          addr_q <= addr_q + REG_AW'(1);  // [R21]
          if (count_q == 8'h00)
            state_q <= ST_CMD;
          else
            count_q <= count_q - 8'h01;
        end
        ST_RD_CNT:
        begin
          count_q <= rx_byte;  // [R10]
          addr_q  <= addr_q + REG_AW'(1);
          state_q <= ST_RD_DATA;
        end
        ST_RD_DATA:
        begin
          if (count_q == 8'h00)
            state_q <= ST_CMD;
          else
          begin
            count_q <= count_q - 8'h01;  // [R10]
            addr_q  <= addr_q + REG_AW'(1);
          end
        end
        default:
          state_q <= ST_CMD;
      endcase
    end
  end

  // configuration registers, one per entry
  generate
    for (genvar i = 0; i < NUM_REGS; i++)
    begin : g_reg
      always_ff @(posedge clk)
      begin
        if (reset || cmd_reset)
          regs_q[i] <= REG_RESET_VALUE;  // [R6]
        else if (wr_strobe && (addr_q == REG_AW'(i)))
          regs_q[i] <= rx_byte;  // [R9] [R21]
      end
    end
  endgenerate

  // read mode
  always_ff @(posedge clk)
  begin
    if (reset || cmd_reset)
      continuous_read_mode_q <= 1'b1;  // [R16]
    else if (cmd_stop)
      continuous_read_mode_q <= 1'b0;  // [R7]
  end

  // power-down entry and exit
  always_ff @(posedge clk)
  begin
    if (reset || cmd_reset)
      power_down_q <= 1'b0;
    else if (cmd_sleep)
      power_down_q <= 1'b1;  // [R15]
    else if (conv_done && !start_s)
      power_down_q <= 1'b1;  // [R19]
    else if (start_rise)
      power_down_q <= 1'b0;  // [R5]
  end

  // conversion timer; a running conversion completes even if start drops
  always_ff @(posedge clk)
  begin
    if (reset || por_busy)
    begin
      conv_cnt_q    <= CNT_W'(CONV_COUNT - 1);
      conv_active_q <= 1'b0;  // [R3]
    end
    else if (cmd_sleep)
      conv_active_q <= 1'b0;  // [R15]
    else if (mux_write && conv_active_q)
      conv_cnt_q <= CNT_W'(SETTLE_COUNT - 1);  // [R18]
    else if (cmd_sync || cmd_reset)
    begin
      conv_cnt_q    <= CNT_W'(CONV_COUNT - 1);  // [R11]
      conv_active_q <= start_s;
    end
    else if (conv_active_q)
    begin
      if (conv_cnt_q == '0)
      begin
        conv_cnt_q    <= CNT_W'(CONV_COUNT - 1);
        conv_active_q <= start_s;  // [R19]
      end
      else
        conv_cnt_q <= conv_cnt_q - CNT_W'(1);
    end
    else if (start_s && !power_down_q)
    begin
      conv_cnt_q    <= CNT_W'(CONV_COUNT - 1);  // [R5]
      conv_active_q <= 1'b1;
    end
  end

  assign conv_done = conv_active_q && (conv_cnt_q == '0);

  // latest result, kept through power-down
  always_ff @(posedge clk)
  begin
    if (reset)
      result_q <= '0;
    else if (conv_done && buf_valid)
      result_q <= buf_data;  // [R20]
  end

  // ready flag: a new result wins over a readout clearing it
  always_ff @(posedge clk)
  begin
    if (reset || por_busy || cmd_reset)
      data_ready_n_n_q <= 1'b1;
    else if (conv_done)
      data_ready_n_n_q <= 1'b0;  // [R13]
    else if (launch_result || cmd_rdata)
      data_ready_n_n_q <= 1'b1;
  end

  // continuous mode pushes the result on the first clock of an idle transaction
  assign launch_result = sclk_rise && (tx_left_q == 5'h00) && continuous_read_mode_q
                         && !data_ready_n_n_q && (state_q == ST_CMD) && (bit_cnt_q == 3'h0);  // [R16]

  // transmit shifter, launched on rising clock edges
  always_ff @(posedge clk)
  begin
    if (reset || cs_n_s)
    begin
      tx_q      <= '0;
      tx_left_q <= 5'h00;  // [R12]
      dout_q    <= data_ready_n_n_q;
    end
    else if (cmd_rdata)
    begin
      tx_q      <= result_q;  // [R14] [R20]
      tx_left_q <= RESULT_BITS;
    end
    else if (rd_load)
    begin
      tx_q      <= {regs_q[addr_q], 8'h00};  // [R10]
      tx_left_q <= BYTE_BITS;
    end
    else if (sclk_rise)
    begin
      if (launch_result)
      begin
        dout_q    <= result_q[RESULT_W-1];  // [R16] [R17]
        tx_q      <= {result_q[RESULT_W-2:0], 1'b0};
        tx_left_q <= RESULT_BITS - 5'h01;
      end
      else if (tx_left_q != 5'h00)
      begin
        dout_q    <= tx_q[RESULT_W-1];  // [R2] [R22]
        tx_q      <= {tx_q[RESULT_W-2:0], 1'b0};
        tx_left_q <= tx_left_q - 5'h01;
      end
      else
        dout_q <= data_ready_n_n_q;  // [R8]
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      oe_q <= 1'b0;
    else
      oe_q <= !cs_n_s && !por_busy;
  end

  assign data_out_ready_pin      = dout_q;
  assign data_out_ready_oe       = oe_q;
  assign data_ready_n            = data_ready_n_n_q;
  assign power_down              = power_down_q;
  assign input_select_register   = regs_q[REG_INPUT_SELECT];
  assign system_control_register = regs_q[REG_SYSTEM_CONTROL];

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  chk_por_quiet: assert property (por_busy |-> data_ready_n_n_q && !conv_active_q) // [R3]
    else $error("activity during power-up hold");
  chk_cs_clears: assert property (cs_n_s |=> state_q == ST_CMD && bit_cnt_q == 3'h0
                                  && tx_left_q == 5'h00) // [R12]
    else $error("chip select high did not clear interface");
  chk_launch_edge: assert property ((!cs_n_s && !sclk_rise) |=> $stable(dout_q)) // [R2]
    else $error("data out changed off a rising edge");
  chk_data_ready_n_falls: assert property (conv_done |=> !data_ready_n) // [R13]
    else $error("ready not asserted after result");
  chk_read_len: assert property (cmd_rdata |=> tx_left_q == RESULT_BITS
                                 && tx_q == $past(result_q)) // [R14]
    else $error("result readout not loaded with 16 bits");
  chk_sleep_enter: assert property (cmd_sleep |=> power_down && !conv_active_q) // [R15]
    else $error("sleep did not power down");
  chk_reset_mode: assert property (cmd_reset |=> continuous_read_mode_q
                                   && power_down == 1'b0) // [R16]
    else $error("reset did not restore continuous mode");
  chk_stop_mode: assert property (cmd_stop |=> !continuous_read_mode_q) // [R7]
    else $error("stop command ignored");
  chk_no_preempt: assert property ((!continuous_read_mode_q && tx_left_q != 5'h00
                                    && !sclk_rise && !sclk_fall && !cs_n_s)
                                   |=> $stable(tx_q) && $stable(tx_left_q)) // [R8]
    else $error("read disturbed by new result");
  chk_settle_load: assert property ((mux_write && conv_active_q && !cmd_sleep)
                                    |=> conv_cnt_q == CNT_W'(SETTLE_COUNT - 1)) // [R18]
    else $error("channel switch timing not loaded");
  chk_block_write: assert property (wr_strobe |=> regs_q[$past(addr_q)] == $past(rx_byte)) // [R9]
    else $error("block write byte not stored");
  chk_stop_finish: assert property ((conv_done && !start_s && !cmd_reset)
                                    |=> power_down ##1 power_down) // [R19]
    else $error("no power-down after final conversion");

  cov_cont_readout: cover property (launch_result ##[1:300] tx_left_q == 5'h00);
  cov_mux_switch: cover property (continuous_read_mode_q && tx_left_q != 5'h00 && mux_write);
  cov_power_down: cover property (conv_done && !start_s);
  cov_reg_read: cover property (rd_load ##[1:300] rd_load);

endmodule

// [src/pair_buffer.sv]
// small valid/ready buffer of flip-flops, default two entries
// assumes both sides on the same clock; in_ready comes from a register
`timescale 1ns/1ps
module pair_buffer #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  input  wire logic             clk,       // system clock
  input  wire logic             reset,     // synchronous, active high
  input  wire logic [WIDTH-1:0] in_data,   // word offered
  input  wire logic             in_valid,  // word offered this cycle
  output logic                  in_ready,  // room for a word
  output logic      [WIDTH-1:0] out_data,  // oldest word
  output logic                  out_valid, // oldest word present
  input  wire logic             out_ready  // consumer takes the word
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W2 = $clog2(DEPTH + 1);

  logic [WIDTH-1:0]  mem_q [DEPTH];
  logic [PTR_W-1:0]  wr_ptr_q;
  logic [PTR_W-1:0]  rd_ptr_q;
  logic [CNT_W2-1:0] count_q;
  logic [CNT_W2-1:0] count_d;
  logic              push;
  logic              pop;

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_valid = (count_q != '0);
  assign out_data  = mem_q[rd_ptr_q];

  always_comb
  begin
    count_d = count_q;
    if (push && !pop)
      count_d = count_q + CNT_W2'(1);
    else if (pop && !push)
      count_d = count_q - CNT_W2'(1);
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
      in_ready <= 1'b1;
    end
    else
    begin
      count_q  <= count_d;
      in_ready <= (count_d < CNT_W2'(DEPTH));
      if (push)
        wr_ptr_q <= (wr_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_q + PTR_W'(1);
      if (pop)
        rd_ptr_q <= (rd_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_q + PTR_W'(1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
      mem_q[wr_ptr_q] <= in_data;
  end

endmodule

// [src/pin_sync.sv]
// two-flop synchroniser for pins arriving from outside the clock domain
// assumes each bit is an independent level
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,      // system clock
  input  wire logic             reset,    // synchronous, active high
  input  wire logic [WIDTH-1:0] async_in, // raw pin levels
  output logic      [WIDTH-1:0] sync_out  // synchronised levels
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      meta_q   <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule
